// ---- rtl/hosc_map.vh ----
`ifndef HOSC_MAP_VH
`define HOSC_MAP_VH
// Register map
`define HOSC_ADDR_W          28
`define HOSC_STAB_SEL_ADDR   28'hffff6c0
`define HOSC_STAB_SEL_RST    8'h06
`define HOSC_CODE_MSB        2
`define HOSC_CODE_BAD        3'h7
`define HOSC_CODE_MAX        3'h6
`define HOSC_EXP_BASE        10
// Counter
`define HOSC_CNT_W           17
`define HOSC_CNT_ONE         17'h00001
`define HOSC_CNT_ZERO        17'h00000
// Modes
`define HOSC_MODE_NORMAL     2'h0
`define HOSC_MODE_STOP       2'h1
`define HOSC_MODE_DEEP_IDLE_MODE      2'h2
`endif

// ---- rtl/hosc_wait_cnt.v ----
`timescale 1ns/1ps
`default_nettype none
`include "hosc_map.vh"
// Binary wait counter: done after 2^(10+code) clocks with run set since start; code 7 counts as code 6
module hosc_wait_cnt (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Control
  input  wire       start,
  input  wire       run,
  input  wire [2:0] code,
  // Status
  output reg        done_q
);
  reg  [`HOSC_CNT_W-1:0] cnt_q;
  wire [`HOSC_CNT_W-1:0] limit;
  // Code 7 is prohibited; it is clamped to the longest legal wait
  wire [2:0]             code_eff;
  assign code_eff = (code == `HOSC_CODE_BAD) ? `HOSC_CODE_MAX : code;
  assign limit    = `HOSC_CNT_ONE << (code_eff + `HOSC_EXP_BASE);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= `HOSC_CNT_ZERO;
      done_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= `HOSC_CNT_ZERO;
      done_q <= 1'b0;
    end else if (run && !done_q) begin
      cnt_q <= cnt_q + `HOSC_CNT_ONE;
      if (cnt_q + `HOSC_CNT_ONE == limit) begin
        done_q <= 1'b1;
      end
    end
  end
endmodule // hosc_wait_cnt
`default_nettype wire

// ---- rtl/hosc_top.v ----
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "hosc_map.vh"
// Summary of operation
// - Select register resets to 06h, longest legal wait.
// - Select register is accessed as a whole byte only.
// - Code n selects 2^(10+n) main clocks; code 7 prohibited.
// - Stop release wait counts only once oscillation has started.
// - After reset release wait 2^16 clocks before using the clock.
// - Halt instruction in normal mode enters CPU halt.
// - In halt only the CPU clock is gated; oscillator and peripherals run.
// - Halt stops execution; RAM kept; independent peripherals keep running.
// - Halt with pending unmasked request enters then leaves at once.
// - Nmi pin, watchdog nmi, unmasked irqs and resets release halt.
// - After halt release the device returns to normal mode.
// - Any nmi or unmasked request releases halt regardless of priority.
// - Lower priority request releases halt, is not acknowledged, stays pending.
// - Higher priority or nmi request releases halt and is acknowledged.
// - Nmi release branches to handler whether irqs enabled or not.
// - Maskable release with irqs disabled runs next instruction.
// - Reset release of halt runs the ordinary reset sequence.
// - Standby release masks have no effect on halt release.
module hosc_top (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst,
  // Register port
  input  wire [`HOSC_ADDR_W-1:0] reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata_q,
  // CPU core
  input  wire                    halt_exec,
  input  wire                    irq_globally_enabled,
  input  wire                    in_isr,
  // Release sources
  input  wire                    nmi_pin,
  input  wire                    watchdog_nonmaskable_irq,
  input  wire                    maskable_irq_pending,
  input  wire                    maskable_irq_higher_prio,
  // Standby control from power save logic
  input  wire [1:0]              standby_mode_req,
  input  wire                    standby_release,
  input  wire                    osc_started,
  input  wire                    wdt_wake_mask,
  input  wire                    pin_nmi_wake_mask,
  input  wire                    maskable_wake_mask,
  // Clock gates and status
  output reg                     cpu_clk_en_q,
  output reg                     sys_clk_en_q,
  output reg                     osc_en_q,
  output reg                     halted_q,
  output reg                     irq_ack_q,
  output reg                     branch_handler_q,
  output reg                     wait_busy_q
);
  // --------------------------------------------------------------
  // State encoding
  // --------------------------------------------------------------
  localparam [4:0] ST_RSTWAIT = 5'h01;
  localparam [4:0] ST_NORMAL  = 5'h02;
  localparam [4:0] ST_HALT    = 5'h04;
  localparam [4:0] ST_STOP    = 5'h08;
  localparam [4:0] ST_WAIT    = 5'h10;

  // Only bits 2..0 exist; upper bits read zero
  function sel_hit;
    input [`HOSC_ADDR_W-1:0] a;
    begin
      sel_hit = (a == `HOSC_STAB_SEL_ADDR);
    end
  endfunction

  // Deep idle shares the stop path: the clock restarts and the wait runs
  // again, trading a little wake latency for one common sequence
  function standby_req;
    input [1:0] m;
    begin
      standby_req = (m == `HOSC_MODE_STOP) || (m == `HOSC_MODE_DEEP_IDLE_MODE);
    end
  endfunction

  reg  [4:0] state_q;
  reg  [4:0] state_d;
  reg  [2:0] code_q;
  reg  [7:0] rdata_d;
  reg        wait_start;
  reg        wait_run;
  wire       wait_done;
  wire       nmi_any;
  wire       halt_wake;

  // Named wait-code bits of the select register
  wire       wait_code_bit2;
  wire       wait_code_bit1;
  wire       wait_code_bit0;
  assign wait_code_bit2 = code_q[2];
  assign wait_code_bit1 = code_q[1];
  assign wait_code_bit0 = code_q[0];

  // --------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------
  localparam [7:0] STAB_SEL_RST = `HOSC_STAB_SEL_RST;

  // Whole-byte writes only; upper bits are dropped, software keeps them zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      code_q <= STAB_SEL_RST[`HOSC_CODE_MSB:0];
    end else if (reg_wr && sel_hit(reg_addr)) begin
      code_q <= reg_wdata[`HOSC_CODE_MSB:0];
    end
  end

  // Read data: the code sits in the low bits, upper bits read zero
  always @* begin
    rdata_d = 8'h00;
    if (reg_rd && sel_hit(reg_addr)) begin
      rdata_d = {5'h00, code_q};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------
  // Halt release decode
  // --------------------------------------------------------------
  // Standby masks are deliberately not used here
  assign nmi_any   = nmi_pin | watchdog_nonmaskable_irq;
  assign halt_wake = nmi_any | maskable_irq_pending;

  // Wake masks belong to the deeper standby modes only
  wire unused_masks = wdt_wake_mask | pin_nmi_wake_mask | maskable_wake_mask;

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always @* begin
    state_d    = state_q;
    wait_start = 1'b0;
    wait_run   = 1'b0;
    case (state_q)
      ST_RSTWAIT: begin
        wait_run = 1'b1;
        if (wait_done) begin
          state_d = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (halt_exec) begin
          state_d = ST_HALT;
        end else if (standby_req(standby_mode_req)) begin
          state_d = ST_STOP;
        end
      end
      ST_HALT: begin
        // A request already pending leaves on the next edge
        if (halt_wake) begin
          state_d = ST_NORMAL;
        end
      end
      ST_STOP: begin
        if (standby_release) begin
          wait_start = 1'b1;
          state_d    = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Start-up before oscillation is not counted
        wait_run = osc_started;
        if (wait_done) begin
          state_d = ST_NORMAL;
        end
      end
      default: begin
        state_d = ST_RSTWAIT;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Output decode helpers
  // --------------------------------------------------------------
  // The CPU clock runs only in normal operation
  function cpu_runs;
    input [4:0] s;
    begin
      cpu_runs = (s == ST_NORMAL);
    end
  endfunction

  // Peripherals keep their clock in normal operation and in halt
  function periph_runs;
    input [4:0] s;
    begin
      periph_runs = (s == ST_NORMAL) || (s == ST_HALT);
    end
  endfunction

  // The oscillator is parked only in the stop state, until standby release
  function osc_runs;
    input [4:0] s;
    begin
      osc_runs = (s != ST_STOP);
    end
  endfunction

  // Both the reset wait and the release wait keep the clocks shut
  function in_wait;
    input [4:0] s;
    begin
      in_wait = (s == ST_RSTWAIT) || (s == ST_WAIT);
    end
  endfunction

  // --------------------------------------------------------------
  // Wake classification
  // --------------------------------------------------------------
  reg ack_d;
  reg branch_d;

  // A maskable request is taken only with irqs enabled and, inside a
  // service routine, only when it outranks the routine's own level.
  // A lower request still wakes the core but stays pending.
  always @* begin
    ack_d    = 1'b0;
    branch_d = 1'b0;
    if (state_q == ST_HALT && halt_wake) begin
      if (nmi_any) begin
        ack_d    = 1'b1;
        branch_d = 1'b1;
      end else if (irq_globally_enabled && (!in_isr || maskable_irq_higher_prio)) begin
        ack_d    = 1'b1;
        branch_d = 1'b1;
      end else begin
        ack_d    = 1'b0;
        branch_d = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Reset release of halt is simply the asynchronous reset path
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RSTWAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------
  // Clock gates
  // --------------------------------------------------------------
  // Gates are registered from the next state so they switch with it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en_q <= 1'b0;
    end else begin
      cpu_clk_en_q <= cpu_runs(state_d);
    end
  end

  // CPU clock gated in halt; peripherals keep their clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_clk_en_q <= 1'b0;
    end else begin
      sys_clk_en_q <= periph_runs(state_d);
    end
  end

  // Standby masks never hold the oscillator; only the stop state parks it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_en_q <= 1'b1;
    end else begin
      osc_en_q <= osc_runs(state_d);
    end
  end

  // --------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------
  // Halted follows the next state so it rises on the entry edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      halted_q <= 1'b0;
    end else begin
      halted_q <= (state_d == ST_HALT);
    end
  end

  // Busy spans both the reset wait and the release wait
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_busy_q <= 1'b1;
    end else begin
      wait_busy_q <= in_wait(state_d);
    end
  end

  // Ack and branch are one-cycle pulses on the halt exit edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ack_q <= 1'b0;
    end else begin
      irq_ack_q <= ack_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      branch_handler_q <= 1'b0;
    end else begin
      branch_handler_q <= branch_d;
    end
  end

  // --------------------------------------------------------------
  // Wait counter
  // --------------------------------------------------------------
  hosc_wait_cnt u_wait (
    .clk    (clk),
    .rst    (rst),
    .start  (wait_start),
    .run    (wait_run),
    .code   ({wait_code_bit2, wait_code_bit1, wait_code_bit0}),
    .done_q (wait_done)
  );
endmodule // hosc_top
`default_nettype wire

// ---- verification/hosc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hosc_map.vh"
module hosc_monitor (
  // Clock, reset and register read
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [`HOSC_ADDR_W-1:0] reg_addr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata_q,
  // Core and release sources
  input wire logic halt_exec, irq_globally_enabled, in_isr, nmi_pin, watchdog_nonmaskable_irq,
  input wire logic maskable_irq_pending, maskable_irq_higher_prio,
  // Gates and status
  input wire logic cpu_clk_en_q, sys_clk_en_q, osc_en_q, halted_q, irq_ack_q, branch_handler_q, wait_busy_q
);
  // ----------------------------------------
  // Halt wake, register read and wait gating checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire nmi_any = nmi_pin | watchdog_nonmaskable_irq;
  wire wake    = nmi_any | maskable_irq_pending;
  sequence s_halt_wake; halted_q && wake; endsequence
  sequence s_mi_wake;   halted_q && !nmi_any && maskable_irq_pending; endsequence
  a_halt_entry: assert property (halt_exec && cpu_clk_en_q |=> halted_q && !cpu_clk_en_q)
    else $error("halt not entered");
  a_halt_gating: assert property (halted_q |-> !cpu_clk_en_q && sys_clk_en_q && osc_en_q)
    else $error("halt gating wrong");
  a_halt_release: assert property (s_halt_wake |=> !halted_q && cpu_clk_en_q)
    else $error("halt not released");
  a_nmi_branch: assert property (halted_q && nmi_any |=> irq_ack_q && branch_handler_q)
    else $error("nmi did not branch");
  a_low_prio_held: assert property (s_mi_wake ##0 (in_isr && !maskable_irq_higher_prio) |=> !irq_ack_q)
    else $error("low priority request acknowledged");
  a_di_next_instr: assert property (s_mi_wake ##0 !irq_globally_enabled |=> !branch_handler_q)
    else $error("branch with irqs disabled");
  a_rd_upper_zero: assert property (reg_rd |=> reg_rdata_q[7:3] == 5'h00)
    else $error("upper read bits not zero");
  a_unmapped_rd: assert property (reg_rd && reg_addr != `HOSC_STAB_SEL_ADDR |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_wait_gated: assert property (wait_busy_q |-> !sys_clk_en_q && !cpu_clk_en_q)
    else $error("clock open during wait");
endmodule // hosc_monitor
bind hosc_top hosc_monitor u_hosc_monitor (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .halt_exec(halt_exec), .irq_globally_enabled(irq_globally_enabled), .in_isr(in_isr),
  .nmi_pin(nmi_pin), .watchdog_nonmaskable_irq(watchdog_nonmaskable_irq), .maskable_irq_pending(maskable_irq_pending),
  .maskable_irq_higher_prio(maskable_irq_higher_prio), .cpu_clk_en_q(cpu_clk_en_q), .sys_clk_en_q(sys_clk_en_q),
  .osc_en_q(osc_en_q), .halted_q(halted_q), .irq_ack_q(irq_ack_q), .branch_handler_q(branch_handler_q),
  .wait_busy_q(wait_busy_q));
`default_nettype wire

// ---- verification/hosc_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Oscillator: needs START_DLY enabled cycles before it reports running
module hosc_osc_model #(parameter int START_DLY = 40) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic osc_en,
  output var  logic osc_started
);
  int cnt_q = 0;
  always @(posedge clk or posedge rst)
    if (rst || !osc_en) cnt_q <= 0;
    else if (cnt_q < START_DLY) cnt_q <= cnt_q + 1;
  assign osc_started = (cnt_q >= START_DLY);
endmodule // hosc_osc_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hosc_map.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, halt_exec = 0, ei = 0, in_isr = 0, nmi = 0, wdt = 0, mi = 0, hi = 0;
  logic standby_release = 0, osc_started, cpu_en, sys_en, osc_en, halted, ack, branch, busy;
  logic [1:0] standby_mode_req = 2'h0;
  logic [`HOSC_ADDR_W-1:0] reg_addr = `HOSC_STAB_SEL_ADDR;
  logic [7:0] reg_wdata = 8'h00, rdata;
  int fail_count = 0, n_checks = 0, n;
  // Wake masks tied set: halt release must not look at them
  hosc_top u_hosc_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(rdata), .halt_exec(halt_exec), .irq_globally_enabled(ei), .in_isr(in_isr),
    .nmi_pin(nmi), .watchdog_nonmaskable_irq(wdt), .maskable_irq_pending(mi), .maskable_irq_higher_prio(hi),
    .standby_mode_req(standby_mode_req), .standby_release(standby_release), .osc_started(osc_started),
    .wdt_wake_mask(1'b1), .pin_nmi_wake_mask(1'b1), .maskable_wake_mask(1'b1), .cpu_clk_en_q(cpu_en),
    .sys_clk_en_q(sys_en), .osc_en_q(osc_en), .halted_q(halted), .irq_ack_q(ack), .branch_handler_q(branch),
    .wait_busy_q(busy));
  hosc_osc_model #(.START_DLY(40)) u_hosc_osc_model (.clk(clk), .rst(rst), .osc_en(osc_en), .osc_started(osc_started));
  initial forever #50 clk = ~clk;
  // ----------------------------------------
  // Bus and wait helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_wdata} <= {1'b1, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [`HOSC_ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) {reg_rd, reg_addr} <= {1'b0, `HOSC_STAB_SEL_ADDR};
    #1 `CHK(rdata, e)
  endtask
  // With from_osc set, wait is timed from oscillation start, not from the release itself
  task automatic measure(input int exp, input bit from_osc);
    n = 0;
    while (from_osc && osc_started !== 1'b1 && n < 1000) begin @(posedge clk); #1 n++; end
    `CHK(cpu_en, 1'b0)
    n = 0;
    while (cpu_en !== 1'b1 && n < 70000) begin @(posedge clk); #1 n++; end
    `CHK(n >= exp && n <= exp + 2, 1'b1)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    #1 `CHK({cpu_en, sys_en, osc_en, busy}, 4'b0011)
    @(posedge clk) rst <= 1'b0;
    measure(65536, 1'b0);
    rd(`HOSC_STAB_SEL_ADDR, `HOSC_STAB_SEL_RST);
    rd(28'h0000000, 8'h00);
    wr(8'h03);
    rd(`HOSC_STAB_SEL_ADDR, 8'h03);
  endtask
  task automatic t_halt;
    // nmi wdt mi ei isr hi pending
    logic [6:0] c [7] = '{7'b1000000, 7'b0101100, 7'b0011000, 7'b0010000, 7'b0011100, 7'b0011110, 7'b0011001};
    logic e;
    for (int i = 0; i < 7; i++) begin
      e = c[i][6] | c[i][5] | (c[i][3] & (!c[i][2] | c[i][1]));
      @(posedge clk) {halt_exec, ei, in_isr, hi} <= {1'b1, c[i][3:1]};
      if (c[i][0]) {nmi, wdt, mi} <= c[i][6:4];
      @(posedge clk) {halt_exec, nmi, wdt, mi} <= {1'b0, c[i][6:4]};
      #1 `CHK({halted, cpu_en, sys_en, osc_en}, 4'b1011)
      @(posedge clk) {nmi, wdt, mi} <= 3'h0;
      #1 `CHK({halted, cpu_en, ack, branch}, {2'b01, e, e})
      @(posedge clk);
    end
  endtask
  task automatic t_stop(input logic [1:0] m, input logic [2:0] code);
    wr({5'h00, code});
    @(posedge clk) standby_mode_req <= m;
    repeat (3) @(posedge clk);
    #1 `CHK({osc_en, cpu_en, sys_en}, 3'b000)
    @(posedge clk) {standby_release, standby_mode_req} <= {1'b1, 2'h0};
    @(posedge clk) standby_release <= 1'b0;
    measure(1 << (10 + code), 1'b1);
  endtask
  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    t_reset;
    t_halt;
    t_stop(`HOSC_MODE_STOP, 3'h0);
    t_stop(`HOSC_MODE_DEEP_IDLE_MODE, 3'h1);
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
